// File: design/adts_pkg.sv
// constants, register map and types of the conversion trigger select block
package adts_pkg;

	// ****************************************************************
	// register indices, byte address is four times the index
	// ****************************************************************
	localparam logic [9:0] IDX_CTRL2    = 10'h112;
	localparam logic [9:0] IDX_TRIG     = 10'h120;
	localparam logic [9:0] IDX_PIN_SEL  = 10'h121;
	localparam logic [9:0] IDX_CHANNEL  = 10'h122;
	localparam logic [9:0] IDX_RES_HIGH = 10'h123;
	localparam logic [9:0] IDX_RES_LOW  = 10'h124;
	localparam logic [9:0] IDX_ERR_HIGH = 10'h125;
	localparam logic [9:0] IDX_ERR_LOW  = 10'h126;
	localparam logic [9:0] IDX_PREV     = 10'h127;
	localparam logic [9:0] IDX_STATUS   = 10'h128;

	// ****************************************************************
	// second control register fields and reset values
	// ****************************************************************
	localparam int         CTRL2_PRECHARGE_POL_BIT = 7;
	localparam int         CTRL2_INV_PRECHARGE_BIT = 6;
	localparam int         CTRL2_GUARD_POL_BIT     = 5;
	localparam int         CTRL2_DOUBLE_SAMPLE_BIT = 0;
	localparam logic [7:0] CTRL2_MASK              = 8'hE1;
	localparam logic [7:0] CTRL2_RST               = 8'h00;
	localparam logic [4:0] TRIG_RST                = 5'h00;
	localparam logic [2:0] PIN_SEL_RST             = 3'h0;
	localparam logic [5:0] CHANNEL_RST             = 6'h00;
	localparam logic [15:0] RESULT_RST             = 16'h0000;

	// ****************************************************************
	// trigger source codes
	// ****************************************************************
	localparam logic [4:0] CODE_OFF      = 5'h00;
	localparam logic [4:0] CODE_PIN      = 5'h01;
	localparam logic [4:0] CODE_NUM_OSC  = 5'h10;
	localparam logic [4:0] CODE_IOC      = 5'h13;
	localparam logic [4:0] CODE_HW_LAST  = 5'h17;
	localparam logic [4:0] CODE_RD_ERR   = 5'h1C;
	localparam logic [4:0] CODE_RD_RES   = 5'h1D;
	localparam logic [4:0] CODE_WR_CHAN  = 5'h1F;

	// ****************************************************************
	// source widths and types
	// ****************************************************************
	localparam int N_HW  = 21;
	localparam int N_PIN = 8;
	localparam int N_IOC = 8;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND} adts_seq_t;

endpackage

// File: design/adts_trig_if.sv
// carrier between trigger control and trigger source selection
`timescale 1ns/100ps
interface adts_trig_if;
	logic [4:0] code;
	logic [2:0] pin_sel;
	logic       hw_event;

	modport sel  (input code, input pin_sel, output hw_event);
	modport ctrl (output code, output pin_sel, input hw_event);
endinterface

// File: design/adts_trig_sel.sv
// trigger source synchroniser, selector and edge detector
`timescale 1ns/100ps
module adts_trig_sel (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// trigger sources
	input  wire logic [adts_pkg::N_HW-1:0]  hw_src,
	input  wire logic [adts_pkg::N_PIN-1:0] pin_in,
	input  wire logic [adts_pkg::N_IOC-1:0] ioc_flag,
	// selection and event towards control
	adts_trig_if.sel                      tif
);

	// ****************************************************************
	// pin synchroniser
	// ****************************************************************
	logic [adts_pkg::N_PIN-1:0] pin_s1_q;
	logic [adts_pkg::N_PIN-1:0] pin_s2_q;
	logic [adts_pkg::N_PIN-1:0] pin_s3_q;
	logic [adts_pkg::N_PIN-1:0] pin_lvl_q;
	logic [adts_pkg::N_PIN-1:0] pin_agree;
	logic [23:0]                src_all;
	logic                       ioc_or;
	logic                       sel_lvl;
	logic                       sel_q;

	// stages two and three agree, so the level may follow stage three
	assign pin_agree = ~(pin_s2_q ^ pin_s3_q);

	// pins are asynchronous; a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q  <= '0;
			pin_s2_q  <= '0;
			pin_s3_q  <= '0;
			pin_lvl_q <= '0;
		end else begin
			pin_s1_q  <= pin_in;
			pin_s2_q  <= pin_s1_q;
			pin_s3_q  <= pin_s2_q;
			// a held level must be able to fall again, or a pin fires only once
			pin_lvl_q <= (pin_s3_q & pin_agree) | (pin_lvl_q & ~pin_agree);
		end
	end

	// ****************************************************************
	// source table, index equals trigger code
	// ****************************************************************
	// internal sources share pclk and need no synchroniser
	assign ioc_or  = |ioc_flag;
	assign src_all = {hw_src[20:17], ioc_or, hw_src[16:0], pin_lvl_q[tif.pin_sel], 1'b0};
	// reserved codes above the table never fire
	assign sel_lvl = (tif.code <= adts_pkg::CODE_HW_LAST) ? src_all[tif.code] : 1'b0;

	// rising edge of the selected source is one event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= sel_lvl;
		end
	end

	assign tif.hw_event = sel_lvl & ~sel_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_ioc_or;
		@(posedge pclk) disable iff (!presetn)
		($stable(tif.code) && tif.code == adts_pkg::CODE_IOC && $rose(ioc_or)) |-> tif.hw_event;
	endproperty
	a_ioc_or: assert property (p_ioc_or) else $error("ioc flag rise gave no event");

	property p_osc_src;
		@(posedge pclk) disable iff (!presetn)
		($stable(tif.code) && tif.code == adts_pkg::CODE_NUM_OSC && $rose(hw_src[14]))
			|-> tif.hw_event;
	endproperty
	a_osc_src: assert property (p_osc_src) else $error("oscillator source not mapped");

endmodule

// File: design/adts_top.sv
// conversion trigger select, second control register and conversion sequencer
`timescale 1ns/100ps
module adts_top (
	// clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// trigger sources
	input  wire logic [adts_pkg::N_HW-1:0]  hw_src,
	input  wire logic [adts_pkg::N_PIN-1:0] pin_in,
	input  wire logic [adts_pkg::N_IOC-1:0] ioc_flag,
	// converter core
	output logic                            conv_start,
	output logic      [5:0]                 conv_channel,
	output logic                            precharge_pol,
	output logic                            guard_pol,
	output logic                            conv_busy,
	input  wire logic                       conv_done,
	input  wire logic [11:0]                conv_data
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [7:0]          ctrl2_q;
	logic [4:0]          trig_code_q;
	logic [2:0]          pin_sel_q;
	logic [5:0]          chan_q;
	logic [15:0]         result_q;
	logic [15:0]         prev_q;
	logic [15:0]         error_q;
	adts_pkg::adts_seq_t state_q;
	logic                seq_double_q;
	logic                conv_start_q;
	logic                precharge_pol_q;
	logic                guard_pol_q;
	logic                busy_q;
	logic [31:0]         prdata_q;
	logic                pready_q;
	logic                pslverr_q;
	logic                acc_done;
	logic                wr_en;
	logic                rd_en;
	logic                hit_ctrl2;
	logic                hit_trig;
	logic                hit_pin;
	logic                hit_chan;
	logic                hit_res_h;
	logic                hit_res_l;
	logic                hit_err_h;
	logic                hit_err_l;
	logic                hit_prev;
	logic                hit_status;
	logic                mapped;
	logic [31:0]         rd_data;
	logic                sw_evt;
	logic                fire;
	logic                inv_second;
	logic [15:0]         data_ext;

	adts_trig_if tif ();

	// ****************************************************************
	// trigger source selection
	// ****************************************************************
	assign tif.code    = trig_code_q;
	assign tif.pin_sel = pin_sel_q;

	adts_trig_sel u_sel (
		.pclk     (pclk),
		.presetn  (presetn),
		.hw_src   (hw_src),
		.pin_in   (pin_in),
		.ioc_flag (ioc_flag),
		.tif      (tif)
	);

	// ****************************************************************
	// apb decode
	// ****************************************************************
	// byte address of a register index, used by every register decode
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	// one wait state keeps prdata and pready straight from flops
	assign acc_done   = psel & penable & pready_q;
	assign wr_en      = acc_done & pwrite;
	assign rd_en      = acc_done & ~pwrite;
	assign hit_ctrl2  = hit(paddr, adts_pkg::IDX_CTRL2);
	assign hit_trig   = hit(paddr, adts_pkg::IDX_TRIG);
	assign hit_pin    = hit(paddr, adts_pkg::IDX_PIN_SEL);
	assign hit_chan   = hit(paddr, adts_pkg::IDX_CHANNEL);
	assign hit_res_h  = hit(paddr, adts_pkg::IDX_RES_HIGH);
	assign hit_res_l  = hit(paddr, adts_pkg::IDX_RES_LOW);
	assign hit_err_h  = hit(paddr, adts_pkg::IDX_ERR_HIGH);
	assign hit_err_l  = hit(paddr, adts_pkg::IDX_ERR_LOW);
	assign hit_prev   = hit(paddr, adts_pkg::IDX_PREV);
	assign hit_status = hit(paddr, adts_pkg::IDX_STATUS);
	assign mapped     = hit_ctrl2 | hit_trig | hit_pin | hit_chan | hit_res_h | hit_res_l
		| hit_err_h | hit_err_l | hit_prev | hit_status;

	// read data selection; unmapped reads return zero
	assign rd_data = hit_ctrl2  ? 32'(ctrl2_q) :
		hit_trig   ? 32'(trig_code_q) :
		hit_pin    ? 32'(pin_sel_q) :
		hit_chan   ? 32'(chan_q) :
		hit_res_h  ? 32'(result_q[15:8]) :
		hit_res_l  ? 32'(result_q[7:0]) :
		hit_err_h  ? 32'(error_q[15:8]) :
		hit_err_l  ? 32'(error_q[7:0]) :
		hit_prev   ? 32'(prev_q) :
		hit_status ? 32'({(state_q == adts_pkg::SEQ_SECOND), busy_q}) :
		32'h0000_0000;

	// answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			prdata_q  <= rd_data;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	// unimplemented bits 4..1 of the second control register stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl2_q     <= adts_pkg::CTRL2_RST;
			trig_code_q <= adts_pkg::TRIG_RST;
			pin_sel_q   <= adts_pkg::PIN_SEL_RST;
			chan_q      <= adts_pkg::CHANNEL_RST;
		end else begin
			if (wr_en && hit_ctrl2) begin
				ctrl2_q <= pwdata[7:0] & adts_pkg::CTRL2_MASK;
			end
			if (wr_en && hit_trig) begin
				trig_code_q <= pwdata[4:0];
			end
			if (wr_en && hit_pin) begin
				pin_sel_q <= pwdata[2:0];
			end
			if (wr_en && hit_chan) begin
				chan_q <= pwdata[5:0];
			end
		end
	end

	// ****************************************************************
	// trigger qualification
	// ****************************************************************
	// register side effects count only at the completing edge of the access
	assign sw_evt = (wr_en & hit_chan & (trig_code_q == adts_pkg::CODE_WR_CHAN))
		| (rd_en & hit_res_h & (trig_code_q == adts_pkg::CODE_RD_RES))
		| (rd_en & hit_err_h & (trig_code_q == adts_pkg::CODE_RD_ERR));
	// events during a running sequence are dropped, not queued
	assign fire = (state_q == adts_pkg::SEQ_IDLE) & (sw_evt | tif.hw_event);
	assign inv_second = ctrl2_q[adts_pkg::CTRL2_INV_PRECHARGE_BIT];
	assign data_ext   = 16'(conv_data);

	// ****************************************************************
	// conversion sequencer
	// ****************************************************************
	// polarities latch at the first start; the second start reads inversion bit 6 live, so a mid-run write to it counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q         <= adts_pkg::SEQ_IDLE;
			seq_double_q    <= 1'b0;
			conv_start_q    <= 1'b0;
			precharge_pol_q <= 1'b0;
			guard_pol_q     <= 1'b0;
		end else begin
			conv_start_q <= 1'b0;
			case (state_q)
				adts_pkg::SEQ_IDLE: begin
					if (fire) begin
						state_q         <= adts_pkg::SEQ_FIRST;
						conv_start_q    <= 1'b1;
						seq_double_q    <= ctrl2_q[adts_pkg::CTRL2_DOUBLE_SAMPLE_BIT];
						precharge_pol_q <= ctrl2_q[adts_pkg::CTRL2_PRECHARGE_POL_BIT];
						guard_pol_q     <= ctrl2_q[adts_pkg::CTRL2_GUARD_POL_BIT];
					end
				end
				adts_pkg::SEQ_FIRST: begin
					if (conv_done && seq_double_q) begin
						state_q         <= adts_pkg::SEQ_SECOND;
						conv_start_q    <= 1'b1;
						precharge_pol_q <= precharge_pol_q ^ inv_second;
						guard_pol_q     <= guard_pol_q ^ inv_second;
					end else if (conv_done) begin
						state_q <= adts_pkg::SEQ_IDLE;
					end
				end
				adts_pkg::SEQ_SECOND: begin
					if (conv_done) begin
						state_q <= adts_pkg::SEQ_IDLE;
					end
				end
				default: begin
					state_q <= adts_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// busy mirrors the sequencer so status and pin agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= fire | ((state_q != adts_pkg::SEQ_IDLE) & ~(conv_done
				& ((state_q == adts_pkg::SEQ_SECOND) | ~seq_double_q)));
		end
	end

	// ****************************************************************
	// result, previous and error registers
	// ****************************************************************
	// error is the last result minus the previous one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= adts_pkg::RESULT_RST;
			prev_q   <= adts_pkg::RESULT_RST;
			error_q  <= adts_pkg::RESULT_RST;
		end else if (conv_done && state_q == adts_pkg::SEQ_FIRST && seq_double_q) begin
			prev_q <= data_ext;
		end else if (conv_done && state_q == adts_pkg::SEQ_FIRST) begin
			prev_q   <= result_q;
			result_q <= data_ext;
			error_q  <= data_ext - result_q;
		end else if (conv_done && state_q == adts_pkg::SEQ_SECOND) begin
			result_q <= data_ext;
			error_q  <= data_ext - prev_q;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign conv_start    = conv_start_q;
	assign conv_channel  = chan_q;
	assign precharge_pol = precharge_pol_q;
	assign guard_pol     = guard_pol_q;
	assign conv_busy     = busy_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_wr_chan;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_chan && trig_code_q == adts_pkg::CODE_WR_CHAN
			&& state_q == adts_pkg::SEQ_IDLE) |=> conv_start && conv_busy;
	endproperty
	a_wr_chan: assert property (p_wr_chan) else $error("channel write did not start");

	property p_rd_res;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && hit_res_h && trig_code_q == adts_pkg::CODE_RD_RES
			&& state_q == adts_pkg::SEQ_IDLE) |=> conv_start;
	endproperty
	a_rd_res: assert property (p_rd_res) else $error("result read did not start");

	property p_rd_err;
		@(posedge pclk) disable iff (!presetn)
		(rd_en && hit_err_h && trig_code_q == adts_pkg::CODE_RD_ERR
			&& state_q == adts_pkg::SEQ_IDLE) |=> conv_start;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("error read did not start");

	property p_off;
		@(posedge pclk) disable iff (!presetn)
		(trig_code_q == adts_pkg::CODE_OFF && state_q == adts_pkg::SEQ_IDLE) |=> !conv_start;
	endproperty
	a_off: assert property (p_off) else $error("start while triggering disabled");

	property p_ctrl2_wr;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_ctrl2) |=> ctrl2_q == ($past(pwdata[7:0]) & adts_pkg::CTRL2_MASK);
	endproperty
	a_ctrl2_wr: assert property (p_ctrl2_wr) else $error("control write not stored");

	property p_double;
		@(posedge pclk) disable iff (!presetn)
		(state_q == adts_pkg::SEQ_FIRST && conv_done && seq_double_q)
			|=> conv_start && prev_q == 16'($past(conv_data)) ##1 !conv_start;
	endproperty
	a_double: assert property (p_double) else $error("double sample sequence wrong");

	property p_invert;
		@(posedge pclk) disable iff (!presetn)
		(state_q == adts_pkg::SEQ_FIRST && conv_done && seq_double_q && inv_second)
			|=> precharge_pol != $past(precharge_pol) && guard_pol != $past(guard_pol);
	endproperty
	a_invert: assert property (p_invert) else $error("second cycle not inverted");

	property p_guard;
		@(posedge pclk) disable iff (!presetn)
		fire |=> guard_pol == $past(ctrl2_q[adts_pkg::CTRL2_GUARD_POL_BIT])
			&& precharge_pol == $past(ctrl2_q[adts_pkg::CTRL2_PRECHARGE_POL_BIT]);
	endproperty
	a_guard: assert property (p_guard) else $error("guard level not taken");

	property p_one_start;
		@(posedge pclk) disable iff (!presetn)
		(conv_start && !seq_double_q) |=> !conv_start throughout (conv_busy [*2]);
	endproperty
	a_one_start: assert property (p_one_start) else $error("extra start in sequence");

endmodule

// File: tb/adts_conv_model.sv
// behavioural converter core that answers each start with one completion
`timescale 1ns/100ps
module adts_conv_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// handshake with the trigger block
	input  wire logic        conv_start,
	input  wire logic [7:0]  lat,
	output logic             conv_done,
	output logic      [11:0] conv_data
);
	// ****************************************************************
	// conversion timer
	// ****************************************************************
	logic [7:0]  cnt_q;
	logic [11:0] n_q;

	// done comes lat cycles after start, never in the start cycle itself;
	// data toggles between answers so stale values are never mistaken for new
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q     <= 8'h00;
			n_q       <= 12'h000;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_start) begin
				cnt_q <= lat;
			end else if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					conv_done <= 1'b1;
					conv_data <= 12'h5A0 + n_q;
					n_q       <= n_q + 12'h001;
				end
			end
		end
	end
endmodule

// File: tb/testbench.sv
// self-checking bench for the conversion trigger select block
`timescale 1ns/100ps
module testbench;
	// ****************************************************************
	// pins and bench state
	// ****************************************************************
	logic                        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic                        pwrite = 1'b0, pready, pslverr, conv_start, conv_done;
	logic                        precharge_pol, guard_pol, conv_busy, err, st_seen = 1'b0;
	logic [11:0]                 paddr = 12'h000, conv_data;
	logic [31:0]                 pwdata = 32'h0000_0000, prdata, rd;
	logic [adts_pkg::N_HW-1:0]   hw_src = '0;
	logic [7:0]                  pin_in = 8'h00, ioc_flag = 8'h00, lat = 8'h04;
	logic [5:0]                  conv_channel;
	logic [1:0]                  pols[$];
	logic [4:0]                  rsv[5] = '{5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1E};
	int                          fail_count = 0, n_checks = 0, start_cnt = 0, base = 0;
	int                          cycles = 0, nconv = 0;

	always #25 pclk = ~pclk;

	adts_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_src(hw_src), .pin_in(pin_in), .ioc_flag(ioc_flag),
		.conv_start(conv_start), .conv_channel(conv_channel), .precharge_pol(precharge_pol),
		.guard_pol(guard_pol), .conv_busy(conv_busy), .conv_done(conv_done),
		.conv_data(conv_data));

	adts_conv_model model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
		.lat(lat), .conv_done(conv_done), .conv_data(conv_data));

	// count starts and keep the polarities of each conversion; cut a hang short
	always @(posedge pclk) begin
		cycles++;
		if (st_seen) pols.push_back({precharge_pol, guard_pol});
		st_seen <= conv_start;
		if (conv_start === 1'b1) start_cnt++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop;
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 20) chk(1'b0, "no pready");
	endtask

	task rdchk(input logic [9:0] idx, input logic [31:0] exp, input string msg);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd === exp && err === 1'b0, msg);
	endtask

	// let a sequence finish, then compare the number of starts it produced
	task expect_starts(input int n, input string msg);
		int k;
		k = 0;
		repeat (8) @(posedge pclk);
		while (conv_busy !== 1'b0 && k < 400) begin
			@(posedge pclk);
			k++;
		end
		chk(start_cnt - base == n, msg);
		base = start_cnt;
		nconv += n;
	endtask

	task pulse_hw(input int i);
		@(posedge pclk);
		hw_src[i] <= 1'b1;
		@(posedge pclk);
		hw_src[i] <= 1'b0;
	endtask

	// pins pass a three-flop synchroniser, so hold them long enough
	task pulse_pin(input logic [7:0] v);
		@(posedge pclk);
		pin_in <= v;
		repeat (4) @(posedge pclk);
		pin_in <= 8'h00;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(adts_pkg::IDX_CTRL2, 32'h0000_0000, "ctrl2 reset");
		apb(1'b1, adts_pkg::IDX_CTRL2, 32'h0000_00FF);
		rdchk(adts_pkg::IDX_CTRL2, 32'h0000_00E1, "ctrl2 bits");
		apb(1'b1, adts_pkg::IDX_CTRL2, 32'h0000_0000);
		apb(1'b0, 10'h200, 32'h0000_0000);
		chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped");
		pulse_hw(0);
		pulse_pin(8'h01);
		expect_starts(0, "code off fired");
		apb(1'b1, adts_pkg::IDX_TRIG, 32'h0000_001F);
		apb(1'b1, adts_pkg::IDX_CHANNEL, 32'h0000_002A);
		expect_starts(1, "channel write");
		chk(conv_channel === 6'h2A, "channel out");
		apb(1'b1, adts_pkg::IDX_TRIG, 32'h0000_001D);
		apb(1'b0, adts_pkg::IDX_RES_HIGH, 32'h0000_0000);
		expect_starts(1, "result read");
		apb(1'b1, adts_pkg::IDX_TRIG, 32'h0000_001C);
		apb(1'b0, adts_pkg::IDX_ERR_HIGH, 32'h0000_0000);
		expect_starts(1, "error read");
		apb(1'b1, adts_pkg::IDX_TRIG, 32'h0000_0013);
		@(posedge pclk);
		ioc_flag <= 8'h20;
		@(posedge pclk);
		ioc_flag <= 8'h00;
		expect_starts(1, "change flag");
		apb(1'b1, adts_pkg::IDX_PIN_SEL, 32'h0000_0003);
		apb(1'b1, adts_pkg::IDX_TRIG, 32'h0000_0001);
		pulse_pin(8'h04);
		expect_starts(0, "other pin");
		pulse_pin(8'h08);
		expect_starts(1, "pin");
		pulse_pin(8'h08);
		expect_starts(1, "pin again");
		for (int c = 2; c < 24; c++) begin
			if (c != 19) begin
				apb(1'b1, adts_pkg::IDX_TRIG, 32'(c));
				pulse_hw(c < 19 ? c - 2 : c - 3);
				expect_starts(1, "hw source");
			end
		end
		// reserved codes are kept but must never start anything
		foreach (rsv[i]) begin
			apb(1'b1, adts_pkg::IDX_TRIG, {27'h0, rsv[i]});
			rdchk(adts_pkg::IDX_TRIG, {27'h0, rsv[i]}, "code store");
			@(posedge pclk);
			hw_src <= '1;
			@(posedge pclk);
			hw_src <= '0;
			apb(1'b1, adts_pkg::IDX_CHANNEL, 32'h0000_0005);
			apb(1'b0, adts_pkg::IDX_RES_HIGH, 32'h0000_0000);
			apb(1'b0, adts_pkg::IDX_ERR_HIGH, 32'h0000_0000);
			expect_starts(0, "reserved fired");
		end
		lat <= 8'h14;
		apb(1'b1, adts_pkg::IDX_TRIG, 32'h0000_0002);
		pulse_hw(0);
		pulse_hw(0);
		rdchk(adts_pkg::IDX_STATUS, 32'h0000_0001, "status busy");
		expect_starts(1, "event while busy");
		lat <= 8'h04;
		apb(1'b1, adts_pkg::IDX_CTRL2, 32'h0000_00E1);
		pulse_hw(0);
		expect_starts(2, "double sample");
		chk(pols[$-1] === 2'b11 && pols[$] === 2'b00, "inverted pols");
		rdchk(adts_pkg::IDX_PREV, {20'h0, 12'h5A0 + 12'(nconv - 2)}, "previous");
		rdchk(adts_pkg::IDX_RES_LOW, {24'h0, 8'hA0 + 8'(nconv - 1)}, "result");
		rdchk(adts_pkg::IDX_ERR_LOW, 32'h0000_0001, "error");
		apb(1'b1, adts_pkg::IDX_CTRL2, 32'h0000_00A1);
		pulse_hw(0);
		expect_starts(2, "double plain");
		chk(pols[$-1] === 2'b11 && pols[$] === 2'b11, "same pols");
		apb(1'b1, adts_pkg::IDX_CTRL2, 32'h0000_0020);
		pulse_hw(0);
		expect_starts(1, "single");
		chk(pols[$] === 2'b01, "guard only");
		report_and_stop;
	end
endmodule
